//--- src/phy_ctl_pkg.sv
package phy_ctl_pkg;

  // clock and timing, each time in its own unit
  localparam int CLK_MHZ       = 25;
  localparam int POR_TIME_US   = 21000;  // power-on hold after supplies are up
  localparam int EXT_TIME_US   = 256;    // soft and power-down reset stretch
  localparam int SW_LIMIT_US   = 500000; // soft reset must end within this
  localparam int MII_SLOW_US   = 16;     // slow mii clock after release
  localparam int ACT_HOLD_US   = 128000; // activity indicator stretch
  localparam int PLL_RST_NS    = 160;    // short pll reset pulse
  localparam int POR_CYC       = POR_TIME_US * CLK_MHZ;
  localparam int EXT_CYC       = EXT_TIME_US * CLK_MHZ;
  localparam int SW_LIMIT_CYC  = SW_LIMIT_US * CLK_MHZ;
  localparam int MII_SLOW_CYC  = MII_SLOW_US * CLK_MHZ;
  localparam int ACT_HOLD_CYC  = ACT_HOLD_US * CLK_MHZ;
  localparam int PLL_RST_CYC   = (PLL_RST_NS * CLK_MHZ) / 1000;
  localparam int CNT_W         = 24;

  // register numbers, used directly as addresses
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_ADV     = 5'h04;
  localparam logic [4:0] REG_MODECTL = 5'h11;
  localparam logic [4:0] REG_STRAPS  = 5'h12;
  localparam logic [4:0] REG_IRQSRC  = 5'h1D;
  localparam logic [4:0] REG_IRQMSK  = 5'h1E;
  localparam logic [4:0] REG_SPECIAL = 5'h1F;

  // field positions
  localparam int CTRL_SOFT_RST = 15;
  localparam int CTRL_LOOP     = 14;
  localparam int CTRL_SPEED    = 13;
  localparam int CTRL_ANEG     = 12;
  localparam int CTRL_PDOWN    = 11;
  localparam int CTRL_ISO      = 10;
  localparam int CTRL_DUPLEX   = 8;
  localparam int CTRL_COLTEST  = 7;
  localparam int MODE_EDPD     = 13;
  localparam int MODE_ENERGY   = 1;
  localparam int IRQ_ENERGY    = 7;
  localparam int SPEC_ISOLATE  = 5;
  localparam int ADV_LSB       = 5;

  // reset values
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [3:0]  ADV_RST     = 4'h0;
  localparam logic [15:0] MODECTL_RST = 16'h0000;
  localparam logic [15:0] SPECIAL_RST = 16'h0040;
  localparam logic [7:0]  IRQMSK_RST  = 8'h00;
  localparam logic [3:0]  ADV_HALF100 = 4'h4;
  localparam logic [3:0]  ADV_ALL     = 4'hF;

  // configuration strap encodings
  localparam logic [2:0] CFG_10H   = 3'h0;
  localparam logic [2:0] CFG_10F   = 3'h1;
  localparam logic [2:0] CFG_100H  = 3'h2;
  localparam logic [2:0] CFG_100F  = 3'h3;
  localparam logic [2:0] CFG_AN100 = 3'h4;
  localparam logic [2:0] CFG_REPT  = 3'h5;
  localparam logic [2:0] CFG_PDOWN = 3'h6;
  localparam logic [2:0] CFG_ALL   = 3'h7;

  // indicator group, one bit each, already polarity adjusted
  typedef struct packed {
    logic activity;
    logic link;
    logic fast_speed;
    logic duplex;
  } led_t;

endpackage

//--- src/phy_reset_led_strap_control.sv
`timescale 1ns/1ps
module phy_reset_led_strap_control
  import phy_ctl_pkg::*;
#(
  parameter int POR_CYCLES      = POR_CYC,
  parameter int EXT_CYCLES      = EXT_CYC,
  parameter int ACT_HOLD_CYCLES = ACT_HOLD_CYC,
  parameter int SW_LIMIT_CYCLES = SW_LIMIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        reset_in_n,
  input  wire logic        line_energy,
  input  wire logic [4:0]  address_strap,
  input  wire logic [2:0]  mode_strap,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        carrier_sense,
  input  wire logic        link_10,
  input  wire logic        link_100,
  input  wire logic        neg_speed_100,
  input  wire logic        neg_full_duplex,
  input  wire logic        neg_active,
  input  wire logic        tx_en,
  input  wire logic        line_collision,
  input  wire logic [4:0]  frame_addr,
  input  wire logic        frame_addr_valid,
  output logic [15:0]      reg_rdata,
  output logic             hardware_reset_src,
  output logic             general_reset,
  output logic             pll_reset,
  output logic             power_down,
  output logic             line_tx_on,
  output logic             energy_present,
  output logic             irq_out_n,
  output logic             mii_clk_fast,
  output logic             loopback_en,
  output logic             collision,
  output logic             repeater_mode,
  output logic [4:0]       scrambler_seed,
  output logic             frame_match,
  output led_t             leds
);

  // elaboration guards: counts must fit the counters and the soft reset must end in time
  if (POR_CYCLES < 1 || POR_CYCLES >= 2**CNT_W || EXT_CYCLES < 1 || EXT_CYCLES >= 2**CNT_W ||
      ACT_HOLD_CYCLES < 1 || ACT_HOLD_CYCLES >= 2**CNT_W) begin : g_bad_count
    $error("phy_reset_led_strap_control: count parameter out of range");
  end
  if (EXT_CYCLES + MII_SLOW_CYC > SW_LIMIT_CYCLES) begin : g_bad_limit
    $error("phy_reset_led_strap_control: soft reset cannot finish in time");
  end

  // polarity: a latched strap of one turns the indicator active low
  function automatic logic led_drive(input logic active, input logic strap_one);
    led_drive = active ^ strap_one;
  endfunction

  // pin synchronisers; first stage feeds only the second
  logic [9:0]  pin_meta_r;
  logic [9:0]  pin_sync_r;
  wire  logic  reset_in_n_s    = pin_sync_r[0];
  wire  logic  energy_s  = pin_sync_r[1];
  wire  logic [4:0] addr_s = pin_sync_r[6:2];
  wire  logic [2:0] mode_s = pin_sync_r[9:7];

  always_ff @(posedge clk) begin
    pin_meta_r <= {mode_strap, address_strap, line_energy, reset_in_n};
    pin_sync_r <= pin_meta_r;
  end

  // state
  logic [CNT_W-1:0] por_cnt_r;
  logic [CNT_W-1:0] sw_cnt_r;
  logic [CNT_W-1:0] pd_cnt_r;
  logic [CNT_W-1:0] act_cnt_r;
  logic [CNT_W-1:0] mii_cnt_r;
  logic [2:0]       pll_cnt_r;
  logic             hw_rst_r;
  logic             gen_rst_r;
  logic             pd_r;
  logic             energy_r;
  logic [15:0]      ctrl_r;
  logic [3:0]       adv_r;
  logic [15:0]      modectl_r;
  logic [15:0]      special_r;
  logic [7:0]       irq_src_r;
  logic [7:0]       irq_msk_r;
  logic [4:0]       addr_latch_r;
  logic [2:0]       mode_latch_r;
  logic [15:0]      rdata_r;
  logic             irq_n_r;
  logic             mii_fast_r;
  logic             col_r;
  logic             line_on_r;
  logic             match_r;
  led_t             leds_r;
  logic             pll_rst_r;
  logic             rept_r;

  // reset sources
  wire logic por_busy   = (por_cnt_r != '0);
  wire logic hw_rst_nxt = por_busy | ~reset_in_n_s;
  wire logic sw_busy    = (sw_cnt_r != '0);
  wire logic pd_busy    = (pd_cnt_r != '0);
  wire logic ctrl_wr    = reg_wr & (reg_addr == REG_CTRL);
  wire logic sw_start   = ctrl_wr & reg_wdata[CTRL_SOFT_RST];
  wire logic sw_rst     = sw_start | sw_busy;
  wire logic edpd_off   = modectl_r[MODE_EDPD] & ~energy_s;
  wire logic pd_nxt     = ctrl_r[CTRL_PDOWN] | edpd_off;
  wire logic pd_exit    = pd_r & ~pd_nxt;
  wire logic gen_rst_nxt = hw_rst_r | sw_rst | pd_r | pd_busy;
  wire logic mgmt_rst   = hw_rst_r | sw_start;
  wire logic gen_rise   = gen_rst_nxt & ~gen_rst_r;

  // power-on, soft and power-down stretch counters
  always_ff @(posedge clk) begin
    if (reset) begin
      por_cnt_r <= CNT_W'(POR_CYCLES);
      sw_cnt_r  <= '0;
      pd_cnt_r  <= '0;
      hw_rst_r  <= 1'b1;
      pd_r      <= 1'b0;
    end else begin
      por_cnt_r <= por_busy ? por_cnt_r - 1'b1 : por_cnt_r;
      hw_rst_r  <= hw_rst_nxt;
      sw_cnt_r  <= sw_start ? CNT_W'(EXT_CYCLES) : (sw_busy ? sw_cnt_r - 1'b1 : sw_cnt_r);
      pd_cnt_r  <= pd_exit ? CNT_W'(EXT_CYCLES) : (pd_busy ? pd_cnt_r - 1'b1 : pd_cnt_r);
      pd_r      <= pd_nxt;
    end
  end

  // merged reset leaves on a register edge, pll gets a short pulse on entry
  wire logic [2:0] pll_cnt_nxt = gen_rise ? 3'(PLL_RST_CYC) : ((pll_cnt_r != '0) ? pll_cnt_r - 3'h1 : pll_cnt_r);
  always_ff @(posedge clk) begin
    if (reset) begin
      gen_rst_r <= 1'b1;
      pll_cnt_r <= 3'(PLL_RST_CYC);
      pll_rst_r <= 1'b1;
    end else begin
      gen_rst_r <= gen_rst_nxt;
      pll_cnt_r <= pll_cnt_nxt;
      pll_rst_r <= (pll_cnt_nxt != 3'h0);                           // pin flop mirrors the count
    end
  end

  // straps are sampled while hardware reset holds, so the last value stays
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_latch_r <= 5'h00;
      mode_latch_r <= 3'h0;
      rept_r       <= 1'b0;
    end else if (hw_rst_r) begin
      addr_latch_r <= addr_s;
      mode_latch_r <= mode_s;
      rept_r       <= (mode_s == CFG_REPT);
    end
  end

  // defaults decoded from the mode straps
  logic [15:0] ctrl_dflt;
  logic [3:0]  adv_dflt;
  always_comb begin
    ctrl_dflt = CTRL_RST;
    adv_dflt  = ADV_RST;
    case (mode_latch_r)
      CFG_10H: ctrl_dflt = CTRL_RST;
      CFG_10F: ctrl_dflt[CTRL_DUPLEX] = 1'b1;
      CFG_100H: ctrl_dflt[CTRL_SPEED] = 1'b1;
      CFG_100F: begin
        ctrl_dflt[CTRL_SPEED]  = 1'b1;
        ctrl_dflt[CTRL_DUPLEX] = 1'b1;
      end
      CFG_AN100, CFG_REPT: begin
        ctrl_dflt[CTRL_SPEED] = 1'b1;
        ctrl_dflt[CTRL_ANEG]  = 1'b1;
        adv_dflt              = ADV_HALF100;
      end
      CFG_PDOWN: ctrl_dflt[CTRL_PDOWN] = 1'b1;
      CFG_ALL: begin
        ctrl_dflt[CTRL_SPEED]  = 1'b1;
        ctrl_dflt[CTRL_ANEG]   = 1'b1;
        ctrl_dflt[CTRL_DUPLEX] = 1'b1;
        adv_dflt               = ADV_ALL;
      end
      default: ctrl_dflt = CTRL_RST;
    endcase
  end

  // management registers; power-down never touches them
  wire logic energy_rise = energy_s & ~energy_r;
  wire logic src_rd      = reg_rd & (reg_addr == REG_IRQSRC);
  wire logic [15:0] ctrl_wval = {1'b0, reg_wdata[14:0]};

  always_ff @(posedge clk) begin
    if (reset || mgmt_rst) begin
      ctrl_r    <= ctrl_dflt;
      adv_r     <= adv_dflt;
      special_r <= SPECIAL_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL)    ctrl_r    <= ctrl_wval;
      if (reg_addr == REG_ADV)     adv_r     <= reg_wdata[ADV_LSB +: 4];
      if (reg_addr == REG_SPECIAL) special_r <= reg_wdata;
    end
  end

  // kept bits: energy-detect enable and the mask survive soft reset
  always_ff @(posedge clk) begin
    if (reset || hw_rst_r) begin
      modectl_r <= MODECTL_RST;
      irq_msk_r <= IRQMSK_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_MODECTL) modectl_r <= reg_wdata;
      if (reg_addr == REG_IRQMSK)  irq_msk_r <= reg_wdata[7:0];
    end
  end

  // interrupt source: a new event in the read cycle is kept
  always_ff @(posedge clk) begin
    if (reset || mgmt_rst) begin
      irq_src_r <= 8'h00;
      energy_r  <= energy_s & ~reset;                               // tracks the pin so no false edge follows
      irq_n_r   <= 1'b1;
    end else begin
      energy_r  <= energy_s;
      irq_src_r[IRQ_ENERGY] <= energy_rise | (irq_src_r[IRQ_ENERGY] & ~src_rd);
      irq_n_r   <= ~((energy_rise | (irq_src_r[IRQ_ENERGY] & ~src_rd)) & irq_msk_r[IRQ_ENERGY]);
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      REG_CTRL:    rd_mux = {sw_rst, ctrl_r[14:0]};
      REG_ADV:     rd_mux = {7'h00, adv_r, 5'h00};
      REG_MODECTL: rd_mux = {modectl_r[15:2], energy_s, modectl_r[0]};
      REG_STRAPS:  rd_mux = {8'h00, mode_latch_r, addr_latch_r};
      REG_IRQSRC:  rd_mux = {8'h00, irq_src_r};
      REG_IRQMSK:  rd_mux = {8'h00, irq_msk_r};
      REG_SPECIAL: rd_mux = special_r;
      default:     rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) rdata_r <= 16'h0000;
    else       rdata_r <= reg_rd ? rd_mux : 16'h0000;
  end

  // mii clock rate: slow window restarts with every general reset
  always_ff @(posedge clk) begin
    if (reset || gen_rst_r) begin
      mii_cnt_r  <= CNT_W'(MII_SLOW_CYC);
      mii_fast_r <= 1'b0;
    end else begin
      mii_cnt_r  <= (mii_cnt_r != '0) ? mii_cnt_r - 1'b1 : mii_cnt_r;
      mii_fast_r <= (mii_cnt_r == '0) & ctrl_r[CTRL_ANEG];
    end
  end

  // indicator sources
  wire logic speed_sel  = ctrl_r[CTRL_ANEG] ? neg_speed_100 : ctrl_r[CTRL_SPEED];
  wire logic duplex_sel = ctrl_r[CTRL_ANEG] ? neg_full_duplex : ctrl_r[CTRL_DUPLEX];
  wire logic act_on     = carrier_sense | (act_cnt_r != '0);
  wire logic link_on    = speed_sel ? link_100 : link_10;
  wire logic fast_on    = (speed_sel | neg_active) & ~special_r[SPEC_ISOLATE];
  wire logic fdx_on     = duplex_sel & link_on;

  // activity stretch reloads while carrier is up
  always_ff @(posedge clk) begin
    if (reset) act_cnt_r <= '0;
    else if (carrier_sense) act_cnt_r <= CNT_W'(ACT_HOLD_CYCLES);
    else if (act_cnt_r != '0) act_cnt_r <= act_cnt_r - 1'b1;
  end

  // indicators follow the latched strap polarity
  always_ff @(posedge clk) begin
    if (reset) begin
      leds_r <= '0;
    end else begin
      leds_r.activity   <= led_drive(act_on, addr_latch_r[0]);
      leds_r.link       <= led_drive(link_on, addr_latch_r[1]);
      leds_r.fast_speed <= led_drive(fast_on, addr_latch_r[2]);
      leds_r.duplex     <= led_drive(fdx_on, addr_latch_r[3]);
    end
  end

  // loopback, collision and line driver; a looped frame never reaches the line
  wire logic loop_on = ctrl_r[CTRL_LOOP];
  wire logic col_nxt = ctrl_r[CTRL_COLTEST] ? tx_en :
                       (~loop_on & ~duplex_sel & line_collision);
  wire logic line_nxt = ~pd_r & ~gen_rst_r & ~(loop_on & tx_en);

  always_ff @(posedge clk) begin
    if (reset) begin
      col_r     <= 1'b0;
      line_on_r <= 1'b0;
      match_r   <= 1'b0;
    end else begin
      col_r     <= col_nxt;
      line_on_r <= line_nxt;
      match_r   <= frame_addr_valid & (frame_addr == addr_latch_r);
    end
  end

  // outputs, each straight from a flip-flop
  assign reg_rdata          = rdata_r;
  assign hardware_reset_src = hw_rst_r;
  assign general_reset      = gen_rst_r;
  assign pll_reset          = pll_rst_r;
  assign power_down         = pd_r;
  assign line_tx_on         = line_on_r;
  assign energy_present     = energy_r;
  assign irq_out_n          = irq_n_r;
  assign mii_clk_fast       = mii_fast_r;
  assign loopback_en        = ctrl_r[CTRL_LOOP];
  assign collision          = col_r;
  assign repeater_mode      = rept_r;
  assign scrambler_seed     = addr_latch_r;
  assign frame_match        = match_r;
  assign leds               = leds_r;

endmodule // phy_reset_led_strap_control

//--- sim/phy_reset_led_strap_control_asserts.sv
`timescale 1ns/1ps
module phy_ctl_asserts
  import phy_ctl_pkg::*;
#(
  parameter int EXT_CYCLES      = 10,
  parameter int SW_LIMIT_CYCLES = 500
) (
  input wire logic        clk, reset, reset_in_n, reg_wr, reg_rd, tx_en, carrier_sense,
  input wire logic        hardware_reset_src, general_reset, pll_reset, power_down, line_tx_on,
  input wire logic        energy_present, irq_out_n, mii_clk_fast, loopback_en, collision,
  input wire logic        frame_addr_valid, frame_match,
  input wire logic [4:0]  reg_addr, frame_addr, scrambler_seed,
  input wire logic [15:0] reg_wdata,
  input wire led_t        leds
);
  localparam int PD_MAX = EXT_CYCLES + 4;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // port-level steps used by the properties; only sw_wr is shared, by two of them
  sequence sw_wr;
    reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_SOFT_RST];
  endsequence
  sequence src_rd;
    reg_rd && reg_addr == REG_IRQSRC && $stable(energy_present);
  endsequence
  sequence pll_pulse;
    pll_reset [*3] ##[1:3] !pll_reset;
  endsequence

  a_pin_to_hw: assert property ($fell(reset_in_n) |-> ##[1:4] hardware_reset_src)
    else $error("pin reset not merged");
  a_hw_to_gen: assert property (hardware_reset_src |-> ##[0:2] general_reset)
    else $error("hardware reset not merged");
  a_pll_short: assert property ($rose(general_reset) |-> ##[0:1] pll_pulse)
    else $error("pll reset pulse wrong");
  a_sw_stretch: assert property (sw_wr |=> general_reset ##EXT_CYCLES general_reset ##1 !general_reset)
    else $error("soft reset stretch wrong");
  a_sw_limit: assert property (sw_wr |-> ##[1:SW_LIMIT_CYCLES] !general_reset)
    else $error("soft reset too long");
  // exit from power-down outside hardware reset keeps the logic held
  a_pd_exit: assert property ($fell(power_down) && !hardware_reset_src
    |-> general_reset [*8] ##[1:PD_MAX] !general_reset)
    else $error("power-down exit reset wrong");
  a_tx_quiet: assert property (power_down || (loopback_en && tx_en) |=> !line_tx_on)
    else $error("line transmitter on");
  a_col_loop: assert property (loopback_en |=> !collision || $past(tx_en))
    else $error("collision in loopback");
  a_irq_read: assert property (src_rd ##1 $stable(energy_present) |-> irq_out_n)
    else $error("irq not released by read");
  a_irq_cause: assert property ($fell(irq_out_n) |-> $rose(energy_present))
    else $error("irq without energy");
  a_frame_eq: assert property (frame_match && !hardware_reset_src
    |-> $past(frame_addr_valid) && $past(frame_addr) == scrambler_seed)
    else $error("frame match wrong");
  a_seed_hold: assert property (!hardware_reset_src [*3] |-> $stable(scrambler_seed))
    else $error("seed moved outside reset");
  // polarity guard: latched straps may still move while hardware reset holds
  a_act_led: assert property (carrier_sense && !general_reset
    |-> ##2 (general_reset || hardware_reset_src || leds.activity != scrambler_seed[0]))
    else $error("activity indicator wrong");
  a_mii_slow: assert property ($fell(general_reset) |-> !mii_clk_fast [*8])
    else $error("mii fast too early");
endmodule // phy_ctl_asserts

//--- sim/board_model.sv
`timescale 1ns/1ps
// board side: reset pin driver and strap resistors
module board_model #(
  parameter int LOW_CYCLES = 2500  // 100 us at 25 MHz
) (
  input  wire logic  clk,
  output logic       reset_in_n,
  output logic [4:0] address_strap,
  output logic [2:0] mode_strap
);
  // straps are always driven, like resistors, never left floating
  initial begin
    reset_in_n    = 1'b1;
    address_strap = 5'h00;
    mode_strap    = 3'h0;
  end

  // straps settle with the pin going low and stay after release
  task automatic pin_reset(input logic [4:0] a, input logic [2:0] m);
    @(posedge clk);
    address_strap <= a;
    mode_strap    <= m;
    reset_in_n    <= 1'b0;
    repeat (LOW_CYCLES) @(posedge clk);
    reset_in_n <= 1'b1;
  endtask
endmodule // board_model

//--- sim/phy_reset_led_strap_control_tb.sv
`timescale 1ns/1ps
module phy_reset_led_strap_control_tb
  import phy_ctl_pkg::*;
;
  localparam int POR_T = 20;
  localparam int EXT_T = 10;
  localparam int ACT_T = 10;
  logic clk = 1'b0, reset = 1'b1, line_energy = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_en = 1'b0;
  logic carrier_sense = 1'b0, link_10 = 1'b0, link_100 = 1'b0, neg_speed_100 = 1'b0, neg_active = 1'b0;
  logic neg_full_duplex = 1'b0, line_collision = 1'b0, frame_addr_valid = 1'b0;
  logic [4:0]  reg_addr = 5'h00, frame_addr = 5'h00, address_strap, scrambler_seed, a;
  logic [2:0]  mode_strap;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
  logic [7:0]  e;
  logic        reset_in_n, hardware_reset_src, general_reset, pll_reset, power_down, line_tx_on, collision;
  logic        energy_present, irq_out_n, mii_clk_fast, loopback_en, repeater_mode, frame_match;
  led_t        leds;
  logic [4:0]  watch;
  int          mismatches = 0, compares = 0, n;

  always #20 clk = ~clk;  // keeps running through every reset
  assign watch = {power_down, leds.activity, mii_clk_fast, general_reset, hardware_reset_src};

  board_model brd (.clk(clk), .reset_in_n(reset_in_n), .address_strap(address_strap), .mode_strap(mode_strap));
  phy_reset_led_strap_control #(.POR_CYCLES(POR_T), .EXT_CYCLES(EXT_T), .ACT_HOLD_CYCLES(ACT_T),
    .SW_LIMIT_CYCLES(500)) DUT (
    .clk(clk), .reset(reset), .reset_in_n(reset_in_n), .line_energy(line_energy),
    .address_strap(address_strap), .mode_strap(mode_strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .carrier_sense(carrier_sense), .link_10(link_10), .link_100(link_100),
    .neg_speed_100(neg_speed_100), .neg_full_duplex(neg_full_duplex), .neg_active(neg_active), .tx_en(tx_en),
    .line_collision(line_collision), .frame_addr(frame_addr), .frame_addr_valid(frame_addr_valid),
    .reg_rdata(reg_rdata), .hardware_reset_src(hardware_reset_src), .general_reset(general_reset),
    .pll_reset(pll_reset), .power_down(power_down), .line_tx_on(line_tx_on), .energy_present(energy_present),
    .irq_out_n(irq_out_n), .mii_clk_fast(mii_clk_fast), .loopback_en(loopback_en), .collision(collision),
    .repeater_mode(repeater_mode), .scrambler_seed(scrambler_seed), .frame_match(frame_match), .leds(leds));

  // expected ctrl bits 13,12,10,8 under a care mask; 111 leaves speed and duplex open
  function automatic logic [7:0] ctrl_exp(input logic [2:0] m);
    if (m == CFG_ALL) return 8'h64;
    if (m == CFG_PDOWN) return 8'h00;
    return {4'hF, m[2] | m[1], m[2], 1'b0, ~m[2] & m[0]};
  endfunction
  // indicator pins: activity is strap bit 0, duplex strap bit 3
  function automatic logic [3:0] led_exp(input logic [3:0] act, input logic [4:0] s);
    return act ^ {s[0], s[1], s[2], s[3]};
  endfunction

  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    compares++;
    if (g !== x) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // counts falling edges until a watched output reaches v; a hang ends the run
  task automatic wait_for(input int i, input logic v, input int lim);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (watch[i] !== v && n <= lim);
    if (watch[i] !== v) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, watch[i], v);
      tally_and_finish();
    end
  endtask
  task automatic edges(input int k);
    repeat (k) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] ad, input logic [15:0] wd);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] ad);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  // main sequence: power-on, every mode strap, then soft reset, power-down, loopback
  initial begin
    void'($urandom(45972));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    wait_for(0, 1'b0, 60);
    chk(n >= POR_T && n <= POR_T + 4, 1'b1);
    for (int m = 0; m < 8; m++) begin
      a = 5'($urandom);
      e = ctrl_exp(3'(m));
      brd.pin_reset(a, 3'(m));
      wait_for(0, 1'b0, 20);
      if (m != 6) wait_for(1, 1'b0, 20);
      if (m == 7) begin
        wait_for(2, 1'b1, 600);
        chk(n >= MII_SLOW_CYC && n <= MII_SLOW_CYC + 3, 1'b1);
      end
      rd(REG_STRAPS);
      chk(d, {8'h00, 3'(m), a});
      chk(scrambler_seed, a);
      rd(REG_CTRL);
      chk({d[13], d[12], d[10], d[8]} & e[7:4], e[3:0]);
      rd(REG_ADV);
      if (m[2] && m != 6) chk(d[8:5], m == 7 ? ADV_ALL : ADV_HALF100);
      chk(power_down, m == 6);
      chk(repeater_mode, m == 5);
      if (m < 4) begin
        @(posedge clk);
        carrier_sense <= 1'b1;
        link_10 <= ~m[1];
        link_100 <= m[1];
        edges(3);
        chk(leds, led_exp({2'b11, 2'(m)}, a));
      end
      if (m == 0) begin
        @(posedge clk);
        carrier_sense <= 1'b0;
        wait_for(3, a[0], 40);
        chk(n >= ACT_T && n <= ACT_T + 4, 1'b1);
      end
      @(posedge clk);
      frame_addr <= a;
      frame_addr_valid <= 1'b1;
      edges(1);
      chk(frame_match, 1'b1);
      @(posedge clk);
      frame_addr <= ~a;
      edges(1);
      chk(frame_match, 1'b0);
    end
    @(posedge clk);
    neg_speed_100 <= 1'b1;
    neg_active <= 1'b1;
    neg_full_duplex <= 1'b1;
    wr(REG_SPECIAL, 16'h0060);
    edges(3);
    chk(leds.fast_speed, a[2]);
    chk(leds.link, !a[1]);
    chk(leds.duplex, !a[3]);
    wr(REG_IRQMSK, 16'h0080);
    wr(REG_CTRL, 16'h8000);
    wait_for(1, 1'b0, 40);
    chk(n >= EXT_T + 1 && n <= EXT_T + 3, 1'b1);
    rd(REG_CTRL);
    chk(d[15], 1'b0);
    rd(REG_SPECIAL);
    chk(d, SPECIAL_RST);
    rd(REG_IRQMSK);
    chk(d, 16'h0080);
    a = 5'($urandom);
    wr(REG_ADV, {7'h00, a[3:0], 5'h00});
    wr(REG_MODECTL, 16'h2000);
    edges(4);
    chk(power_down, 1'b1);
    chk(line_tx_on, 1'b0);
    @(posedge clk);
    line_energy <= 1'b1;
    wait_for(4, 1'b0, 10);
    chk(irq_out_n, 1'b0);
    chk(general_reset, 1'b1);
    wait_for(1, 1'b0, 30);
    chk(n >= EXT_T - 1 && n <= EXT_T + 3, 1'b1);
    rd(REG_ADV);
    chk(d[8:5], a[3:0]);
    rd(REG_IRQSRC);
    chk(d[7], 1'b1);
    chk(irq_out_n, 1'b1);
    rd(REG_MODECTL);
    chk(d, 16'h2002);
    wr(REG_CTRL, 16'h4000);
    @(posedge clk);
    tx_en <= 1'b1;
    line_collision <= 1'b1;
    edges(2);
    chk(loopback_en, 1'b1);
    chk(line_tx_on, 1'b0);
    chk(collision, 1'b0);
    wr(REG_CTRL, 16'h4080);
    edges(2);
    chk(collision, 1'b1);
    wr(REG_CTRL, 16'h0000);
    edges(2);
    chk(line_tx_on, 1'b1);
    rd(5'h03);
    chk(d, 16'h0000);
    tally_and_finish();
  end
endmodule // phy_reset_led_strap_control_tb

bind phy_reset_led_strap_control phy_ctl_asserts #(.EXT_CYCLES(EXT_CYCLES), .SW_LIMIT_CYCLES(SW_LIMIT_CYCLES)) chk_i (
  .clk(clk), .reset(reset), .reset_in_n(reset_in_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .tx_en(tx_en),
  .carrier_sense(carrier_sense), .hardware_reset_src(hardware_reset_src), .general_reset(general_reset),
  .pll_reset(pll_reset), .power_down(power_down), .line_tx_on(line_tx_on), .energy_present(energy_present),
  .irq_out_n(irq_out_n), .mii_clk_fast(mii_clk_fast), .loopback_en(loopback_en), .collision(collision),
  .frame_addr_valid(frame_addr_valid), .frame_match(frame_match), .reg_addr(reg_addr),
  .frame_addr(frame_addr), .scrambler_seed(scrambler_seed), .reg_wdata(reg_wdata), .leds(leds));
